//--- common/lpmc_pkg.sv
// Constants, register map and state encoding of the low-power mode controller.
// Assumes a 20 MHz system clock that equals the core clock being gated.
package lpmc_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CNT_W = 18;
  localparam int ONCHIP_N = 8;
  localparam int AXI_AW = 8;

  // Register byte addresses
  localparam logic [7:0] ADDR_IO_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CPU_CTRL = 8'h04;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // Field positions
  localparam int IO_STOP_POSITION = 5;
  localparam int QUICK_RECOVERY_POS = 3;
  localparam int STOP_BUS_GRANT_POSITION = 5;
  localparam int STANDBY_SELECT_POS = 6;
  localparam int CLOCK_DIVIDE_POS = 7;
  localparam int EXT_IRQ_N = 3;
  localparam int ONCHIP_EN_LSB = 8;

  // Reset values and writable bits
  localparam logic [7:0] IO_CTRL_RST = 8'h00;
  localparam logic [7:0] CPU_CTRL_RST = 8'h00;
  localparam logic [15:0] IRQ_EN_RST = 16'h0000;
  localparam logic [7:0] IO_CTRL_WMASK = 8'h20;
  localparam logic [7:0] CPU_CTRL_WMASK = 8'hE8;
  localparam logic [15:0] IRQ_EN_WMASK = 16'hFF07;

  // On-chip sources halted by io-stop (serial channels, clocked serial, timers)
  localparam logic [ONCHIP_N-1:0] IO_HALTED_MASK = 8'h1F;

  // Restart times in half clock periods, then whole cycles rounded up
  localparam int SLEEP_WAKE_HALF_CLK = 3;
  localparam int IDLE_WAKE_HALF_CLK = 19;
  localparam logic [CNT_W-1:0] SLEEP_WAKE_CYC = CNT_W'((SLEEP_WAKE_HALF_CLK + 1) / 2);
  localparam logic [CNT_W-1:0] IDLE_WAKE_CYC = CNT_W'((IDLE_WAKE_HALF_CLK + 1) / 2);
  localparam logic [CNT_W-1:0] IDLE_BUS_EXTRA_CYC = 18'h0_0008;
  localparam logic [CNT_W-1:0] STBY_QUICK_CYC = 18'h0_0040;
  localparam logic [CNT_W-1:0] STBY_SLOW_CYC = 18'h2_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN, ST_SLEEP, ST_SYSSTOP, ST_IDLE, ST_STANDBY, ST_WAKE, ST_GRANT_WAIT, ST_GRANT
  } lpmc_state_t;
endpackage

//--- common/lpmc_cnt_if.sv
// Carrier between the mode controller and its delay counter.
// Assumes both ends run on the same clock.
interface lpmc_cnt_if;
  logic load;
  logic [lpmc_pkg::CNT_W-1:0] load_val;
  logic busy;
  logic done;
  modport ctl (output load, output load_val, input busy, input done);
  modport cnt (input load, input load_val, output busy, output done);
endinterface

//--- design/lpmc_sync.sv
// Two-flop synchroniser for pin inputs.
// Assumes idle level of every pin is high.
module lpmc_sync #(
  parameter int W = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lpmc_sync_st_t;
  lpmc_sync_st_t st_reg, st_next;

  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule

//--- design/lpmc_down_cnt.sv
// Restart and grant delay counter; done is high in the cycle the count expires.
// Assumes load is a one-cycle pulse with a nonzero value.
module lpmc_down_cnt (
  input wire logic aclk,
  input wire logic aresetn,
  lpmc_cnt_if.cnt cif
);
  typedef struct packed {
    logic busy;
    logic [lpmc_pkg::CNT_W-1:0] cnt;
  } lpmc_cnt_st_t;
  lpmc_cnt_st_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (cif.load) begin
      st_next.busy = 1'b1;
      st_next.cnt = cif.load_val;
    end else if (st_reg.busy) begin
      st_next.cnt = st_reg.cnt - 1'b1;
      st_next.busy = (st_reg.cnt != 18'h0_0001);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cif.busy = st_reg.busy;
  assign cif.done = st_reg.busy && (st_reg.cnt == 18'h0_0001) && !cif.load;
endmodule

//--- design/lpmc_ctrl.sv
// Low-power mode controller: sleep, system stop, idle and standby entry and exit,
// clock gating, stop-mode bus grant and the system clock divider.
// Assumes an AXI4-Lite master on aclk, core inputs on aclk, pins asynchronous.
// Summary of operation
// - Sleep with all mode bits clear gates core, DMA and refresh; I/O runs.
// - Individually disabled interrupt sources never wake the device from sleep.
// - Enabled wake with global flag set services interrupt, return after sleep.
// - Enabled wake with global flag clear resumes at next instruction, no interrupt.
// - Sleep restart takes about one and a half clocks.
// - Io-stop halts serial channels and timers; clearing it restores them.
// - Sleep with io-stop set, standby select and quick recovery clear halts CPU and I/O; clock output keeps running.
// - System stop wakes like sleep, but io-stop-halted sources cannot wake.
// - Io-stop set, standby select clear, quick recovery set enters idle.
// - Idle keeps oscillator but blocks all clocks and output; refresh stops.
// - Idle exits only on reset, non-maskable or enabled external interrupt.
// - Idle restart takes about nine and a half clocks.
// - Idle bus grant with enable set responds eight cycles later than normal.
// - After bus request withdraws in idle, clock output gates off again.
// - Io-stop and standby select set enters standby, stopping the oscillator.
// - Standby interrupt exit waits 131072 clocks, or 64 with quick recovery.
// - Standby bus grant waits the same stabilisation delay.
// - Standby exit services interrupt on non-maskable or global flag set.
// - Waking maskable line released before delay ends keeps device in standby.
// - Reset selects divide-by-two; the divide bit then picks two or one.
module lpmc_ctrl #(
  parameter logic [lpmc_pkg::CNT_W-1:0] STBY_SLOW_CYC = lpmc_pkg::STBY_SLOW_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [lpmc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lpmc_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_instruction,
  input wire logic global_interrupt_flag,
  input wire logic [lpmc_pkg::ONCHIP_N-1:0] onchip_irq,
  input wire logic [lpmc_pkg::EXT_IRQ_N-1:0] ext_irq_n,
  input wire logic nmi_n,
  input wire logic busreq_n,
  output logic busack_n,
  output logic cpu_clk_en,
  output logic dma_clk_en,
  output logic io_clk_en,
  output logic refresh_en,
  output logic system_clock_output_en,
  output logic osc_run,
  output logic sys_tick,
  output logic resume,
  output logic irq_take
);
  typedef struct packed {
    lpmc_pkg::lpmc_state_t state;
    logic from_stby;
    logic wake_nmi;
    logic quick_l;
    logic [7:0] io_control_reg;
    logic [7:0] cpu_control_reg;
    logic [15:0] irq_en_reg;
    logic div_ph;
    logic run_ack;
    logic aw_full;
    logic [lpmc_pkg::AXI_AW-1:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lpmc_ctrl_st_t;

  lpmc_ctrl_st_t st_reg, st_next;
  lpmc_cnt_if cif ();
  logic [lpmc_pkg::EXT_IRQ_N+1:0] pins_s;
  logic [lpmc_pkg::EXT_IRQ_N-1:0] ext_act;
  logic [lpmc_pkg::ONCHIP_N-1:0] onchip_act;
  logic nmi_act, busreq_act, ext_wake, io_stop, stop_bus_grant_enable, wake_sleep, wake_stop;
  logic load;
  logic [lpmc_pkg::CNT_W-1:0] load_val;

  lpmc_sync #(
    .W(lpmc_pkg::EXT_IRQ_N + 2)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({busreq_n, nmi_n, ext_irq_n}),
    .q(pins_s)
  );

  lpmc_down_cnt u_cnt (
    .aclk(aclk),
    .aresetn(aresetn),
    .cif(cif)
  );

  assign ext_act = ~pins_s[lpmc_pkg::EXT_IRQ_N-1:0] & st_reg.irq_en_reg[lpmc_pkg::EXT_IRQ_N-1:0];
  assign nmi_act = !pins_s[lpmc_pkg::EXT_IRQ_N];
  assign busreq_act = !pins_s[lpmc_pkg::EXT_IRQ_N+1];
  assign onchip_act = onchip_irq & st_reg.irq_en_reg[lpmc_pkg::ONCHIP_EN_LSB +: lpmc_pkg::ONCHIP_N];
  assign ext_wake = |ext_act;
  assign io_stop = st_reg.io_control_reg[lpmc_pkg::IO_STOP_POSITION];
  assign stop_bus_grant_enable = st_reg.cpu_control_reg[lpmc_pkg::STOP_BUS_GRANT_POSITION];
  // Disabled sources are already masked out of the act vectors
  assign wake_sleep = ext_wake || nmi_act || (|onchip_act);
  assign wake_stop = ext_wake || nmi_act || (|(onchip_act & ~lpmc_pkg::IO_HALTED_MASK));

  always_comb begin
    st_next = st_reg;
    load = 1'b0;
    load_val = lpmc_pkg::SLEEP_WAKE_CYC;
    st_next.run_ack = busreq_act;
    // Divide-by-two alternates the tick; divide-by-one ticks every cycle
    st_next.div_ph = !st_reg.div_ph;

    case (st_reg.state)
      lpmc_pkg::ST_RUN: begin
        if (sleep_instruction) begin
          // Mode bits taken as they stand at the sleep instruction
          st_next.quick_l = st_reg.cpu_control_reg[lpmc_pkg::QUICK_RECOVERY_POS];
          if (!io_stop) begin
            st_next.state = lpmc_pkg::ST_SLEEP;
          end else if (st_reg.cpu_control_reg[lpmc_pkg::STANDBY_SELECT_POS]) begin
            st_next.state = lpmc_pkg::ST_STANDBY;
          end else if (st_reg.cpu_control_reg[lpmc_pkg::QUICK_RECOVERY_POS]) begin
            st_next.state = lpmc_pkg::ST_IDLE;
          end else begin
            st_next.state = lpmc_pkg::ST_SYSSTOP;
          end
        end
      end
      lpmc_pkg::ST_SLEEP, lpmc_pkg::ST_SYSSTOP: begin
        if ((st_reg.state == lpmc_pkg::ST_SLEEP) ? wake_sleep : wake_stop) begin
          load = 1'b1;
          load_val = lpmc_pkg::SLEEP_WAKE_CYC;
          st_next.wake_nmi = nmi_act;
          st_next.from_stby = 1'b0;
          st_next.state = lpmc_pkg::ST_WAKE;
        end
      end
      lpmc_pkg::ST_IDLE, lpmc_pkg::ST_STANDBY: begin
        st_next.from_stby = (st_reg.state == lpmc_pkg::ST_STANDBY);
        // Only pins wake these modes; on-chip sources have no clock
        if (ext_wake || nmi_act) begin
          load = 1'b1;
          st_next.wake_nmi = nmi_act;
          st_next.state = lpmc_pkg::ST_WAKE;
          if (st_reg.state == lpmc_pkg::ST_IDLE) begin
            load_val = lpmc_pkg::IDLE_WAKE_CYC;
          end else begin
            load_val = st_reg.quick_l ? lpmc_pkg::STBY_QUICK_CYC : STBY_SLOW_CYC;
          end
        end else if (stop_bus_grant_enable && busreq_act) begin
          load = 1'b1;
          st_next.state = lpmc_pkg::ST_GRANT_WAIT;
          if (st_reg.state == lpmc_pkg::ST_IDLE) begin
            load_val = lpmc_pkg::IDLE_BUS_EXTRA_CYC;
          end else begin
            load_val = st_reg.quick_l ? lpmc_pkg::STBY_QUICK_CYC : STBY_SLOW_CYC;
          end
        end
      end
      lpmc_pkg::ST_WAKE: begin
        if (st_reg.from_stby && !st_reg.wake_nmi && !ext_wake) begin
          // Maskable line dropped during stabilisation
          st_next.state = lpmc_pkg::ST_STANDBY;
        end else if (cif.done) begin
          st_next.state = lpmc_pkg::ST_RUN;
        end
      end
      lpmc_pkg::ST_GRANT_WAIT: begin
        if (!busreq_act) begin
          st_next.state = st_reg.from_stby ? lpmc_pkg::ST_STANDBY : lpmc_pkg::ST_IDLE;
        end else if (cif.done) begin
          st_next.state = lpmc_pkg::ST_GRANT;
        end
      end
      lpmc_pkg::ST_GRANT: begin
        if (!busreq_act) begin
          st_next.state = st_reg.from_stby ? lpmc_pkg::ST_STANDBY : lpmc_pkg::ST_IDLE;
        end
      end
      default: begin
        st_next.state = lpmc_pkg::ST_RUN;
      end
    endcase

    // Register bus: address and data are taken independently
    if (s_axi_awvalid && !st_reg.aw_full) begin
      st_next.aw_full = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_full) begin
      st_next.w_full = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid) begin
      st_next.aw_full = 1'b0;
      st_next.w_full = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = lpmc_pkg::RESP_OKAY;
      if (st_reg.awaddr == lpmc_pkg::ADDR_IO_CTRL) begin
        if (st_reg.wstrb[0]) begin
          // Io-stop write takes effect at once; clearing it restores I/O
          st_next.io_control_reg = st_reg.wdata[7:0] & lpmc_pkg::IO_CTRL_WMASK;
        end
      end else if (st_reg.awaddr == lpmc_pkg::ADDR_CPU_CTRL) begin
        if (st_reg.wstrb[0]) begin
          st_next.cpu_control_reg = st_reg.wdata[7:0] & lpmc_pkg::CPU_CTRL_WMASK;
        end
      end else if (st_reg.awaddr == lpmc_pkg::ADDR_IRQ_EN) begin
        if (st_reg.wstrb[0]) begin
          st_next.irq_en_reg[7:0] = st_reg.wdata[7:0] & lpmc_pkg::IRQ_EN_WMASK[7:0];
        end
        if (st_reg.wstrb[1]) begin
          st_next.irq_en_reg[15:8] = st_reg.wdata[15:8] & lpmc_pkg::IRQ_EN_WMASK[15:8];
        end
      end else if (st_reg.awaddr != lpmc_pkg::ADDR_STATUS) begin
        st_next.bresp = lpmc_pkg::RESP_SLVERR;
      end
    end

    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = lpmc_pkg::RESP_OKAY;
      st_next.rdata = '0;
      if (s_axi_araddr == lpmc_pkg::ADDR_IO_CTRL) begin
        st_next.rdata[7:0] = st_reg.io_control_reg;
      end else if (s_axi_araddr == lpmc_pkg::ADDR_CPU_CTRL) begin
        st_next.rdata[7:0] = st_reg.cpu_control_reg;
      end else if (s_axi_araddr == lpmc_pkg::ADDR_IRQ_EN) begin
        st_next.rdata[15:0] = st_reg.irq_en_reg;
      end else if (s_axi_araddr == lpmc_pkg::ADDR_STATUS) begin
        st_next.rdata[7:0] = {2'h0, ~busack_n, busreq_act, nmi_act, st_reg.state};
      end else begin
        st_next.rresp = lpmc_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.state <= lpmc_pkg::ST_RUN;
      st_reg.io_control_reg <= lpmc_pkg::IO_CTRL_RST;
      st_reg.cpu_control_reg <= lpmc_pkg::CPU_CTRL_RST;
      st_reg.irq_en_reg <= lpmc_pkg::IRQ_EN_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cif.load = load;
  assign cif.load_val = load_val;

  assign s_axi_awready = !st_reg.aw_full;
  assign s_axi_wready = !st_reg.w_full;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;

  // Clock gating follows the mode; only run state clocks the core
  assign cpu_clk_en = (st_reg.state == lpmc_pkg::ST_RUN);
  assign dma_clk_en = (st_reg.state == lpmc_pkg::ST_RUN);
  assign refresh_en = (st_reg.state == lpmc_pkg::ST_RUN);
  assign io_clk_en = !io_stop && ((st_reg.state == lpmc_pkg::ST_RUN) ||
                                  (st_reg.state == lpmc_pkg::ST_SLEEP));
  // Clock output stays on through sleep and system stop, off in idle
  assign system_clock_output_en = (st_reg.state == lpmc_pkg::ST_RUN) ||
                                  (st_reg.state == lpmc_pkg::ST_SLEEP) ||
                                  (st_reg.state == lpmc_pkg::ST_SYSSTOP) ||
                                  (st_reg.state == lpmc_pkg::ST_GRANT) ||
                                  ((st_reg.state == lpmc_pkg::ST_WAKE) && !st_reg.from_stby);
  // Oscillator restarts as soon as standby is left for a wake or grant wait
  assign osc_run = (st_reg.state != lpmc_pkg::ST_STANDBY);
  assign sys_tick = st_reg.cpu_control_reg[lpmc_pkg::CLOCK_DIVIDE_POS] || st_reg.div_ph;
  assign resume = (st_reg.state == lpmc_pkg::ST_WAKE) && cif.done &&
                  !(st_reg.from_stby && !st_reg.wake_nmi && !ext_wake);
  // Interrupt taken on non-maskable or global flag, else plain resume
  assign irq_take = resume && (st_reg.wake_nmi || global_interrupt_flag);
  // Normal grant one cycle after request; stop-mode grant via the delay
  assign busack_n = !((st_reg.state == lpmc_pkg::ST_GRANT) ||
                      (st_reg.run_ack && ((st_reg.state == lpmc_pkg::ST_RUN) ||
                                          (st_reg.state == lpmc_pkg::ST_SLEEP) ||
                                          (st_reg.state == lpmc_pkg::ST_SYSSTOP))));

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_sleep_wake;
    (st_reg.state == lpmc_pkg::ST_SLEEP) && wake_sleep;
  endsequence
  sequence seq_idle_wake;
    (st_reg.state == lpmc_pkg::ST_IDLE) && (ext_wake || nmi_act);
  endsequence
  sequence seq_idle_grant;
    (st_reg.state == lpmc_pkg::ST_IDLE) && !ext_wake && !nmi_act && stop_bus_grant_enable && busreq_act;
  endsequence

  AST_SLEEP_GATES: assert property ((st_reg.state == lpmc_pkg::ST_SLEEP) |->
      !cpu_clk_en && !dma_clk_en && !refresh_en && (io_clk_en == !io_stop))
    else $error("sleep clock gating wrong");
  AST_SLEEP_HOLD: assert property (((st_reg.state == lpmc_pkg::ST_SLEEP) && !wake_sleep) |=>
      (st_reg.state == lpmc_pkg::ST_SLEEP))
    else $error("sleep left without enabled source");
  AST_TAKE_FLAG: assert property ((resume && !st_reg.wake_nmi) |->
      (irq_take == global_interrupt_flag))
    else $error("interrupt take does not follow global flag");
  AST_SLEEP_LAT: assert property (seq_sleep_wake |-> !resume ##1 !resume ##1 resume)
    else $error("sleep restart latency wrong");
  AST_IO_STOP_BIT: assert property (io_stop |-> !io_clk_en)
    else $error("io clock running under io-stop");
  AST_SYSSTOP: assert property ((st_reg.state == lpmc_pkg::ST_SYSSTOP) |->
      !cpu_clk_en && !io_clk_en && system_clock_output_en)
    else $error("system stop gating wrong");
  AST_SYSSTOP_MASK: assert property (((st_reg.state == lpmc_pkg::ST_SYSSTOP) && !wake_stop) |=>
      (st_reg.state == lpmc_pkg::ST_SYSSTOP))
    else $error("system stop woken by halted source");
  AST_IDLE_GATE: assert property ((st_reg.state == lpmc_pkg::ST_IDLE) |->
      !system_clock_output_en && osc_run && !refresh_en && !cpu_clk_en)
    else $error("idle gating wrong");
  AST_IDLE_LAT: assert property (seq_idle_wake |-> (!resume)[*8] ##1 !resume ##1 !resume ##1 resume)
    else $error("idle restart latency wrong");
  AST_IDLE_GRANT: assert property (seq_idle_grant ##1 busreq_act[*8] |->
      ##1 !busack_n)
    else $error("idle grant latency wrong");
  AST_GRANT_REL: assert property (((st_reg.state == lpmc_pkg::ST_GRANT) && !st_reg.from_stby &&
      !busreq_act) |=> (st_reg.state == lpmc_pkg::ST_IDLE) && !system_clock_output_en)
    else $error("idle grant release wrong");
  AST_STBY_OSC: assert property ((st_reg.state == lpmc_pkg::ST_STANDBY) |->
      !osc_run && !system_clock_output_en)
    else $error("oscillator running in standby");
  AST_STBY_ABORT: assert property (((st_reg.state == lpmc_pkg::ST_WAKE) && st_reg.from_stby &&
      !st_reg.wake_nmi && !ext_wake) |=> (st_reg.state == lpmc_pkg::ST_STANDBY))
    else $error("standby wake not abandoned");
  // Tick phase is frozen during reset, so the first cycle after release is skipped
  AST_DIV2: assert property (($past(aresetn) &&
      !st_reg.cpu_control_reg[lpmc_pkg::CLOCK_DIVIDE_POS] &&
      !$past(st_reg.cpu_control_reg[lpmc_pkg::CLOCK_DIVIDE_POS])) |-> (sys_tick != $past(sys_tick)))
    else $error("divide-by-two tick wrong");
endmodule

//--- dv/lpmc_far_end.sv
// External bus master and external interrupt pins facing the controller.
// Assumes the bench moves the pins on a clock edge; idle level is high.
module lpmc_far_end (
  input wire logic aclk,
  input wire logic busack_n,
  output logic [2:0] ext_irq_n = 3'h7,
  output logic nmi_n = 1'b1,
  output logic busreq_n = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  // Request, count cycles to grant, hold three cycles, withdraw
  task automatic bus_cycle(output int n);
    n = 0;
    @(posedge aclk);
    busreq_n <= 1'b0;
    while (busack_n !== 1'b0 && n < 300) begin
      @(negedge aclk);
      n++;
    end
    repeat (3) @(posedge aclk);
    busreq_n <= 1'b1;
  endtask
  // Pin levels {nmi, irq2..0} change only just after a rising edge
  task automatic drive(input logic [3:0] v);
    @(posedge aclk);
    {nmi_n, ext_irq_n} <= v;
  endtask
endmodule

//--- dv/test_low_power_mode_control.sv
// Self-checking bench for the low-power mode controller.
// Assumes the slow standby count is shortened to 100 cycles.
module test_low_power_mode_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busack_n, nmi_n, busreq_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic sleep_instruction = 1'b0, global_interrupt_flag = 1'b0;
  logic [7:0] onchip_irq = 8'h00;
  logic [2:0] ext_irq_n;
  logic cpu_clk_en, dma_clk_en, io_clk_en, refresh_en, system_clock_output_en, osc_run, sys_tick, resume, irq_take;
  int fail_count = 0, total_checks = 0, cyc = 0;
  lpmc_ctrl #(.STBY_SLOW_CYC(18'h0_0064)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sleep_instruction, .global_interrupt_flag, .onchip_irq, .ext_irq_n, .nmi_n, .busreq_n, .busack_n,
    .cpu_clk_en, .dma_clk_en, .io_clk_en, .refresh_en, .system_clock_output_en, .osc_run, .sys_tick,
    .resume, .irq_take);
  lpmc_far_end far (.aclk, .busack_n, .ext_irq_n, .nmi_n, .busreq_n);
  always #25 aclk = ~aclk;
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic c, input string m);
    total_checks++;
    if (c !== 1'b1) begin
      fail_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp === 2'h0, "bresp");
  endtask
  // Read data is only judged on an OKAY answer
  task automatic rdr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp === er && (er !== 2'h0 || s_axi_rdata === exp), "read");
  endtask
  task automatic go_sleep(input logic gf);
    @(posedge aclk);
    {sleep_instruction, global_interrupt_flag} <= {1'b1, gf};
    @(posedge aclk);
    sleep_instruction <= 1'b0;
    @(negedge aclk);
  endtask
  task automatic wait_res(input int lim, output int n);
    n = 0;
    while (resume !== 1'b1 && n < lim) begin
      @(negedge aclk);
      n++;
    end
  endtask
  task automatic t_reset();
    logic t0;
    rdr(lpmc_pkg::ADDR_CPU_CTRL, 32'h0000_0000);
    rdr(8'h10, 32'h0000_0000, 2'h2);
    @(negedge aclk);
    t0 = sys_tick;
    @(negedge aclk);
    chk(sys_tick === ~t0 && cpu_clk_en === 1'b1, "div two");
    wr(lpmc_pkg::ADDR_CPU_CTRL, 32'h0000_0080);
    @(negedge aclk);
    t0 = sys_tick;
    @(negedge aclk);
    chk(sys_tick === 1'b1 && t0 === 1'b1, "div one");
  endtask
  task automatic t_sleep(input logic gf);
    int n;
    wr(lpmc_pkg::ADDR_IRQ_EN, 32'h0000_0001);
    onchip_irq <= 8'h80;
    go_sleep(gf);
    chk(cpu_clk_en === 1'b0 && refresh_en === 1'b0 && io_clk_en === 1'b1, "sleep gates");
    wait_res(20, n);
    chk(n == 20, "disabled woke");
    far.drive(4'hE);
    wait_res(30, n);
    chk(n >= 2 && n <= 6 && irq_take === gf, "sleep wake");
    far.drive(4'hF);
    onchip_irq <= 8'h00;
  endtask
  task automatic t_stop();
    int n;
    wr(lpmc_pkg::ADDR_IO_CTRL, 32'h0000_0020);
    chk(io_clk_en === 1'b0 && cpu_clk_en === 1'b1, "io stop");
    wr(lpmc_pkg::ADDR_IRQ_EN, 32'h0000_2101);
    onchip_irq <= 8'h01;
    go_sleep(1'b1);
    chk(cpu_clk_en === 1'b0 && system_clock_output_en === 1'b1, "sys stop");
    wait_res(20, n);
    chk(n == 20, "halted woke");
    @(posedge aclk);
    onchip_irq <= 8'h20;
    wait_res(30, n);
    chk(n >= 1 && n <= 6, "stop wake");
    @(posedge aclk);
    onchip_irq <= 8'h00;
  endtask
  task automatic t_idle();
    int n, nr;
    wr(lpmc_pkg::ADDR_CPU_CTRL, 32'h0000_0028);
    far.bus_cycle(nr);
    go_sleep(1'b0);
    rdr(lpmc_pkg::ADDR_STATUS, 32'h0000_0003);
    chk(system_clock_output_en === 1'b0 && io_clk_en === 1'b0, "idle clocks");
    far.bus_cycle(n);
    chk(n >= 9 && n <= 14 && n - nr == 8, "idle grant");
    onchip_irq <= 8'h20;
    wait_res(12, n);
    chk(n == 12 && system_clock_output_en === 1'b0, "idle held");
    far.drive(4'hE);
    onchip_irq <= 8'h00;
    wait_res(30, n);
    chk(n >= 10 && n <= 14 && irq_take === 1'b0, "idle wake");
    far.drive(4'hF);
  endtask
  task automatic t_standby();
    int n;
    wr(lpmc_pkg::ADDR_CPU_CTRL, 32'h0000_0040);
    go_sleep(1'b1);
    chk(osc_run === 1'b0, "standby osc");
    far.drive(4'hE);
    wait_res(50, n);
    far.drive(4'hF);
    wait_res(150, n);
    chk(n == 150 && osc_run === 1'b0, "abandon");
    far.drive(4'hE);
    wait_res(200, n);
    chk(n >= 100 && n <= 105 && irq_take === 1'b1, "standby wake");
    far.drive(4'hF);
    // Quick recovery with stop-mode grant, then a non-maskable wake with the global flag clear
    wr(lpmc_pkg::ADDR_CPU_CTRL, 32'h0000_0068);
    go_sleep(1'b0);
    far.bus_cycle(n);
    chk(n >= 66 && n <= 70, "standby grant");
    far.drive(4'h7);
    wait_res(100, n);
    chk(n >= 64 && n <= 69 && irq_take === 1'b1, "nmi wake");
    far.drive(4'hF);
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_sleep(1'b1);
    t_sleep(1'b0);
    t_stop();
    t_idle();
    t_standby();
    wrap_up();
  end
endmodule
